// File: inc/pcrs_pkg.sv
// Constants and types for the program counter and return stack unit.
// Notes on behaviour
// - Each reset copies the top four program memory words into configuration registers.
// - Configuration bytes run upward: word one low byte first, word four high last.
// - Program counter is 21 bits: low byte accessible, middle and upper bytes only via latches.
// - Writing the low byte loads middle and upper bytes from the latches.
// - Reading the low byte copies middle and upper bytes into the latches.
// - Counter bit zero is always zero; sequential execution adds two.
// - Call, relative call, goto and branch load the counter directly, never from latches.
// - Calls and interrupts push, returns pop; none of these touches the latches.
// - Return stack holds 31 entries of 21 bits behind a 5-bit pointer.
// - Push increments then writes; pop reads then decrements.
// - Pointer resets to zero; value zero is the empty state without storage.
// - Three top-entry registers read and write the entry under the pointer.
// - Thirty-one pushes set the full flag; only software or power-on clear it.
// - With fault reset enabled, the 31st push stores next address, sets full, resets device.
// - With fault reset disabled, further pushes leave the pointer at 31 and never overwrite entry 31.
// - Pop when empty loads zero, sets underflow, keeps pointer zero; flag is sticky.
// - Full or underflow sets its flag, then resets the device only when enabled.
// - Pointer register: bit 7 full, bit 6 underflow, bit 5 zero, bits 4-0 pointer.
// - Software push increments the pointer and stores the counter in the new top.
// - Software pop drops the top entry by decrementing the pointer.
// - Shadow copies of status, working and bank registers load on interrupt, restore on fast return.
// - Fast call saves the three registers to the shadow; fast return restores them.
package pcrs_pkg;

  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STK_DEPTH = 31;
  localparam int CFG_BYTES = 8;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_PC_LOW = 4'h0;
  localparam logic [3:0] OFF_PC_HIGH_LATCH = 4'h1;
  localparam logic [3:0] OFF_PC_UPPER_LATCH = 4'h2;
  localparam logic [3:0] OFF_STACK_POINTER = 4'h3;
  localparam logic [3:0] OFF_TOP_LOW = 4'h4;
  localparam logic [3:0] OFF_TOP_HIGH = 4'h5;
  localparam logic [3:0] OFF_TOP_UPPER = 4'h6;
  localparam logic [3:0] OFF_CONFIG_BASE = 4'h8;

  localparam int SPR_FULL_BIT = 7;
  localparam int SPR_UNF_BIT = 6;
  localparam logic [7:0] SPR_RESET = 8'h00;
  localparam logic [4:0] SP_RESET = 5'h00;
  localparam logic [4:0] SP_TOP = 5'h1f;
  localparam logic [4:0] SP_LAST_FREE = 5'h1e;

  // ---------------------------------------------------------------
  // Configuration copy
  // ---------------------------------------------------------------
  localparam logic [20:0] CFG_BASE_ADDR = 21'h007ff8;
  localparam logic [3:0] CFG_LAST_IDX = 4'h7;
  localparam int CFG_FAULT_BYTE = 6;
  localparam int CFG_FAULT_BIT = 5;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;

  typedef enum logic [3:0] {
    OP_NONE, OP_SEQ, OP_CALL, OP_RELATIVE_CALL, OP_GOTO, OP_BRANCH, OP_RETURN,
    OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_INTACK, OP_PUSH, OP_POP
  } pcrs_op_e;

  typedef enum logic [1:0] {LD_COPY, LD_RUN} pcrs_load_e;

  typedef struct packed {
    pcrs_op_e op;
    logic fast;
    logic [20:0] target;
  } pcrs_cmd_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } pcrs_ctx_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcrs_reg_s;

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] latHigh;
    logic [4:0] latUpper;
    logic [4:0] sp;
    logic full;
    logic unf;
    logic [STK_DEPTH-1:0][20:0] stack;
    pcrs_ctx_s shadow;
    logic [CFG_BYTES-1:0][7:0] cfg;
    pcrs_load_e ld;
    logic [3:0] issueIdx;
    logic [3:0] capIdx;
    logic memRd;
    logic [20:0] memAddr;
    logic pend;
    logic [7:0] rdData;
    logic restoreValid;
    logic faultReq;
  } pcrs_state_s;

endpackage

// File: rtl/pcrs_core.sv
// Program counter, return stack, shadow registers and configuration copy.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module pcrs_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire pcrs_pkg::pcrs_reg_s regReq,
  output logic [7:0] regRdata,
  input wire pcrs_pkg::pcrs_cmd_s cmd,
  input wire pcrs_pkg::pcrs_ctx_s ctxNow,
  output pcrs_pkg::pcrs_ctx_s ctxRestore,
  output logic restoreValid,
  output logic [20:0] pc,
  output logic faultResetReq,
  output logic cfgBusy,
  output logic [63:0] cfgBytes,
  output logic memRd,
  output logic [20:0] memAddr,
  input wire logic [7:0] memData
);

  pcrs_pkg::pcrs_state_s st_q;
  pcrs_pkg::pcrs_state_s st_d;
  logic faultEnable;
  logic running;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Pointer value k lives in storage slot k-1; value zero has no slot.
  function automatic logic [4:0] slotOf(input logic [4:0] sp);
    slotOf = sp - 5'h01;
  endfunction

  function automatic logic [20:0] topOf(input pcrs_pkg::pcrs_state_s s);
    topOf = (s.sp == 5'h00) ? 21'h000000 : s.stack[slotOf(s.sp)];
  endfunction

  assign faultEnable = st_q.cfg[pcrs_pkg::CFG_FAULT_BYTE][pcrs_pkg::CFG_FAULT_BIT];
  assign running = (st_q.ld == pcrs_pkg::LD_RUN);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [20:0] nextPc;
    logic [20:0] topVal;
    logic doPush;
    logic doPop;
    logic [20:0] pushVal;
    nextPc = 21'h000000;
    topVal = 21'h000000;
    doPush = 1'b0;
    doPop = 1'b0;
    pushVal = 21'h000000;
    st_d = st_q;
    st_d.restoreValid = 1'b0;
    st_d.faultReq = 1'b0;
    st_d.memRd = 1'b0;
    st_d.pend = st_q.memRd;

    // Configuration copy after every reset, lowest address first.
    if (st_q.ld == pcrs_pkg::LD_COPY) begin
      if (st_q.issueIdx <= pcrs_pkg::CFG_LAST_IDX) begin
        st_d.memRd = 1'b1;
        st_d.memAddr = pcrs_pkg::CFG_BASE_ADDR + {17'h00000, st_q.issueIdx};
        st_d.issueIdx = st_q.issueIdx + 4'h1;
      end
      if (st_q.pend) begin
        st_d.cfg[st_q.capIdx[2:0]] = memData;
        st_d.capIdx = st_q.capIdx + 4'h1;
        if (st_q.capIdx == pcrs_pkg::CFG_LAST_IDX) begin
          st_d.ld = pcrs_pkg::LD_RUN;
        end
      end
    end

    // Register reads: data stands in the following cycle.
    st_d.rdData = 8'h00;
    if (regReq.rd) begin
      case (regReq.addr)
        pcrs_pkg::OFF_PC_LOW: begin
          st_d.rdData = st_q.pc[7:0];
          st_d.latHigh = st_q.pc[15:8];
          st_d.latUpper = st_q.pc[20:16];
        end
        pcrs_pkg::OFF_PC_HIGH_LATCH: st_d.rdData = st_q.latHigh;
        pcrs_pkg::OFF_PC_UPPER_LATCH: st_d.rdData = {3'h0, st_q.latUpper};
        pcrs_pkg::OFF_STACK_POINTER: st_d.rdData = {st_q.full, st_q.unf, 1'b0, st_q.sp};
        pcrs_pkg::OFF_TOP_LOW: st_d.rdData = topOf(st_q)[7:0];
        pcrs_pkg::OFF_TOP_HIGH: st_d.rdData = topOf(st_q)[15:8];
        pcrs_pkg::OFF_TOP_UPPER: st_d.rdData = {3'h0, topOf(st_q)[20:16]};
        default: begin
          if (regReq.addr >= pcrs_pkg::OFF_CONFIG_BASE) begin
            st_d.rdData = st_q.cfg[regReq.addr[2:0]];
          end
        end
      endcase
    end

    // Register writes come before core operations of the same cycle.
    if (regReq.wr) begin
      case (regReq.addr)
        pcrs_pkg::OFF_PC_LOW: begin
          st_d.pc = {st_q.latUpper, st_q.latHigh, regReq.wdata[7:1], 1'b0};
        end
        pcrs_pkg::OFF_PC_HIGH_LATCH: st_d.latHigh = regReq.wdata;
        pcrs_pkg::OFF_PC_UPPER_LATCH: st_d.latUpper = regReq.wdata[4:0];
        pcrs_pkg::OFF_STACK_POINTER: begin
          st_d.sp = regReq.wdata[4:0];
          st_d.full = st_q.full & regReq.wdata[pcrs_pkg::SPR_FULL_BIT];
          st_d.unf = st_q.unf & regReq.wdata[pcrs_pkg::SPR_UNF_BIT];
        end
        pcrs_pkg::OFF_TOP_LOW: begin
          if (st_q.sp != 5'h00) begin
            st_d.stack[slotOf(st_q.sp)][7:0] = regReq.wdata;
          end
        end
        pcrs_pkg::OFF_TOP_HIGH: begin
          if (st_q.sp != 5'h00) begin
            st_d.stack[slotOf(st_q.sp)][15:8] = regReq.wdata;
          end
        end
        pcrs_pkg::OFF_TOP_UPPER: begin
          if (st_q.sp != 5'h00) begin
            st_d.stack[slotOf(st_q.sp)][20:16] = regReq.wdata[4:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Core operations; ignored while the configuration copy runs.
    nextPc = st_d.pc + pcrs_pkg::PC_STEP;
    if (running) begin
      case (cmd.op)
        pcrs_pkg::OP_SEQ: st_d.pc = nextPc;
        pcrs_pkg::OP_GOTO, pcrs_pkg::OP_BRANCH: begin
          st_d.pc = {cmd.target[20:1], 1'b0};
        end
        pcrs_pkg::OP_CALL, pcrs_pkg::OP_RELATIVE_CALL: begin
          doPush = 1'b1;
          pushVal = nextPc;
          st_d.pc = {cmd.target[20:1], 1'b0};
          if (cmd.fast) begin
            st_d.shadow = ctxNow;
          end
        end
        pcrs_pkg::OP_INTACK: begin
          doPush = 1'b1;
          pushVal = st_d.pc;
          st_d.pc = {cmd.target[20:1], 1'b0};
          st_d.shadow = ctxNow;
        end
        pcrs_pkg::OP_RETURN, pcrs_pkg::OP_RETURN_WITH_LITERAL, pcrs_pkg::OP_RETURN_FROM_INTERRUPT: begin
          doPop = 1'b1;
          if (cmd.fast && cmd.op != pcrs_pkg::OP_RETURN_WITH_LITERAL) begin
            st_d.restoreValid = 1'b1;
          end
        end
        pcrs_pkg::OP_PUSH: begin
          doPush = 1'b1;
          pushVal = st_d.pc;
          st_d.pc = nextPc;
        end
        pcrs_pkg::OP_POP: begin
          st_d.pc = nextPc;
          if (st_d.sp != 5'h00) begin
            st_d.sp = st_d.sp - 5'h01;
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware pushes and pops; flag sets win over software clears.
    if (doPush) begin
      if (st_d.sp != pcrs_pkg::SP_TOP) begin
        st_d.sp = st_d.sp + 5'h01;
        st_d.stack[slotOf(st_d.sp)] = pushVal;
        if (st_d.sp == pcrs_pkg::SP_TOP) begin
          st_d.full = 1'b1;
          st_d.faultReq = faultEnable;
        end
      end
    end
    if (doPop) begin
      topVal = topOf(st_d);
      if (st_d.sp == 5'h00) begin
        st_d.pc = pcrs_pkg::PC_RESET;
        st_d.unf = 1'b1;
        st_d.faultReq = faultEnable;
      end else begin
        st_d.pc = {topVal[20:1], 1'b0};
        st_d.sp = st_d.sp - 5'h01;
      end
    end

    // Device reset keeps the sticky flags; only power-on clears them.
    if (rst) begin
      st_d.pc = pcrs_pkg::PC_RESET;
      st_d.latHigh = 8'h00;
      st_d.latUpper = 5'h00;
      st_d.sp = pcrs_pkg::SP_RESET;
      st_d.stack = '0;
      st_d.shadow = '0;
      st_d.cfg = '0;
      st_d.ld = pcrs_pkg::LD_COPY;
      st_d.issueIdx = 4'h0;
      st_d.capIdx = 4'h0;
      st_d.memRd = 1'b0;
      st_d.memAddr = pcrs_pkg::CFG_BASE_ADDR;
      st_d.pend = 1'b0;
      st_d.rdData = 8'h00;
      st_d.restoreValid = 1'b0;
      st_d.faultReq = 1'b0;
      st_d.full = por ? 1'b0 : st_q.full;
      st_d.unf = por ? 1'b0 : st_q.unf;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regRdata = st_q.rdData;
  assign ctxRestore = st_q.shadow;
  assign restoreValid = st_q.restoreValid;
  assign pc = st_q.pc;
  assign faultResetReq = st_q.faultReq;
  assign cfgBusy = ~running;
  assign cfgBytes = st_q.cfg;
  assign memRd = st_q.memRd;
  assign memAddr = st_q.memAddr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = running & ~regReq.wr;

  sequence emptyPop;
    quiet && st_q.sp == 5'h00 && cmd.op == pcrs_pkg::OP_RETURN;
  endsequence

  sequence flaggedUnderflow;
    st_q.unf && st_q.pc == 21'h000000 && st_q.sp == 5'h00;
  endsequence

  pc_align_a: assert property (st_q.pc[0] == 1'b0)
    else $error("program counter bit zero is set");

  seq_step_a: assert property (quiet && cmd.op == pcrs_pkg::OP_SEQ
    |=> st_q.pc == $past(st_q.pc) + 21'h000002)
    else $error("sequential step is not two");

  low_write_a: assert property (running && regReq.wr && regReq.addr == pcrs_pkg::OFF_PC_LOW
    && cmd.op == pcrs_pkg::OP_NONE
    |=> st_q.pc == {$past(st_q.latUpper), $past(st_q.latHigh), $past(regReq.wdata[7:1]), 1'b0})
    else $error("low byte write did not load latches");

  low_read_a: assert property (regReq.rd && regReq.addr == pcrs_pkg::OFF_PC_LOW && !regReq.wr
    |=> st_q.latHigh == $past(st_q.pc[15:8]) && st_q.latUpper == $past(st_q.pc[20:16]))
    else $error("low byte read did not fill latches");

  goto_direct_a: assert property (quiet && cmd.op == pcrs_pkg::OP_GOTO
    |=> st_q.pc == {$past(cmd.target[20:1]), 1'b0} && $stable(st_q.latHigh))
    else $error("goto did not load target");

  call_push_a: assert property (quiet && cmd.op == pcrs_pkg::OP_CALL && st_q.sp < 5'h1e
    |=> st_q.sp == $past(st_q.sp) + 5'h01
    ##0 st_q.stack[slotOf(st_q.sp)] == $past(st_q.pc) + 21'h000002)
    else $error("call push wrong");

  full_set_a: assert property (quiet && cmd.op == pcrs_pkg::OP_CALL && st_q.sp == 5'h1e
    |=> st_q.full && st_q.sp == 5'h1f ##0 st_q.faultReq == $past(faultEnable))
    else $error("31st push did not set full");

  stuck_top_a: assert property (quiet && cmd.op == pcrs_pkg::OP_PUSH && st_q.sp == 5'h1f
    |=> st_q.sp == 5'h1f && $stable(st_q.stack[30]))
    else $error("push past top moved pointer");

  empty_pop_a: assert property (emptyPop |=> flaggedUnderflow)
    else $error("empty pop wrong");

  fault_reset_a: assert property (emptyPop ##0 faultEnable |=> st_q.faultReq ##1 !st_q.faultReq)
    else $error("underflow did not request reset");

  ptr_read_a: assert property (regReq.rd && regReq.addr == pcrs_pkg::OFF_STACK_POINTER
    |=> regRdata[5] == 1'b0 && regRdata[4:0] == $past(st_q.sp))
    else $error("pointer register read wrong");

  shadow_load_a: assert property (running && cmd.op == pcrs_pkg::OP_INTACK
    |=> st_q.shadow == $past(ctxNow))
    else $error("shadow not loaded on interrupt");

  ptr_reset_a: assert property (@(posedge clk) disable iff (1'b0) rst |=> st_q.sp == 5'h00)
    else $error("pointer not zero after reset");

endmodule

// File: tb/pcrs_core_tb_top.sv
// Self-checking testbench for the program counter and return stack unit.
`timescale 1ns/1ps
module pcrs_core_tb_top;
  typedef struct packed {
    pcrs_pkg::pcrs_op_e op;
    logic [20:0] tgt;
    logic [20:0] pc;
    logic [4:0] sp;
    logic [7:0] top;
  } pcrs_row_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic faultEn = 1'b0;
  pcrs_pkg::pcrs_reg_s regReq = '0;
  pcrs_pkg::pcrs_cmd_s cmd = '0;
  pcrs_pkg::pcrs_ctx_s ctxNow = '0;
  logic [7:0] memData = 8'h00;
  logic [7:0] regRdata;
  pcrs_pkg::pcrs_ctx_s ctxRestore;
  logic restoreValid;
  logic [20:0] pc;
  logic faultResetReq;
  logic cfgBusy;
  logic [63:0] cfgBytes;
  logic memRd;
  logic [20:0] memAddr;
  pcrs_row_s rows [11];
  logic [7:0] topSeen;
  int nErrors = 0;
  int nCompared = 0;

  always #2.5 clk = ~clk;

  pcrs_core u_dut (.clk(clk), .rst(rst), .por(por), .regReq(regReq), .regRdata(regRdata),
    .cmd(cmd), .ctxNow(ctxNow), .ctxRestore(ctxRestore), .restoreValid(restoreValid),
    .pc(pc), .faultResetReq(faultResetReq), .cfgBusy(cfgBusy), .cfgBytes(cfgBytes),
    .memRd(memRd), .memAddr(memAddr), .memData(memData));

  // Program memory answers only inside the top eight bytes of the 32 KB space.
  function automatic logic [7:0] cfgByte(input logic [20:0] a);
    if (a[20:3] != 18'h00fff) return 8'h00;
    if (a[2:0] == 3'h6) return {2'b00, faultEn, 5'h06};
    return {5'h12, a[2:0]};
  endfunction

  always @(posedge clk) begin
    if (memRd) memData <= cfgByte(memAddr);
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic finalReport();
    if (nErrors == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regWr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.wr <= 1'b1;
    regReq.addr <= a;
    regReq.wdata <= d;
    @(posedge clk);
    regReq.wr <= 1'b0;
    #1;
  endtask

  task automatic regRd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    regRd(a, d);
    chk(d, exp);
  endtask

  task automatic doOp(input pcrs_pkg::pcrs_op_e op, input logic fast, input logic [20:0] tgt);
    @(posedge clk);
    cmd.op <= op;
    cmd.fast <= fast;
    cmd.target <= tgt;
    @(posedge clk);
    cmd.op <= pcrs_pkg::OP_NONE;
    cmd.fast <= 1'b0;
    #1;
  endtask

  task automatic doReset(input logic porV, input logic fe);
    logic [63:0] exp;
    int k;
    @(posedge clk);
    rst <= 1'b1;
    por <= porV;
    faultEn <= fe;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    k = 0;
    @(posedge clk);
    while (cfgBusy !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    #1;
    for (int i = 0; i < 8; i++) exp[8*i +: 8] = cfgByte(21'h007ff8 + 21'(i));
    chk(cfgBusy, 1'b0);
    chk(cfgBytes, exp);
    chk(pc, 21'h0);
  endtask

  task automatic pushN(input int n);
    for (int i = 0; i < n; i++) doOp(pcrs_pkg::OP_PUSH, 1'b0, 21'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    finalReport();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rows[0] = '{pcrs_pkg::OP_SEQ, 21'h0, 21'h000002, 5'd0, 8'h00};
    rows[1] = '{pcrs_pkg::OP_GOTO, 21'h001235, 21'h001234, 5'd0, 8'h00};
    rows[2] = '{pcrs_pkg::OP_CALL, 21'h000100, 21'h000100, 5'd1, 8'h36};
    rows[3] = '{pcrs_pkg::OP_RELATIVE_CALL, 21'h000200, 21'h000200, 5'd2, 8'h02};
    rows[4] = '{pcrs_pkg::OP_BRANCH, 21'h000300, 21'h000300, 5'd2, 8'h02};
    rows[5] = '{pcrs_pkg::OP_INTACK, 21'h000008, 21'h000008, 5'd3, 8'h00};
    rows[6] = '{pcrs_pkg::OP_PUSH, 21'h0, 21'h00000a, 5'd4, 8'h08};
    rows[7] = '{pcrs_pkg::OP_POP, 21'h0, 21'h00000c, 5'd3, 8'h00};
    rows[8] = '{pcrs_pkg::OP_RETURN_FROM_INTERRUPT, 21'h0, 21'h000300, 5'd2, 8'h02};
    rows[9] = '{pcrs_pkg::OP_RETURN_WITH_LITERAL, 21'h0, 21'h000102, 5'd1, 8'h36};
    rows[10] = '{pcrs_pkg::OP_RETURN, 21'h0, 21'h001236, 5'd0, 8'h00};
    doReset(1'b1, 1'b0);
    rdChk(4'h3, 8'h00);
    rdChk(4'h7, 8'h00);
    rdChk(4'he, 8'h06);
    regWr(4'he, 8'hff);
    rdChk(4'he, 8'h06);
    foreach (rows[i]) begin
      doOp(rows[i].op, 1'b0, rows[i].tgt);
      chk(pc, rows[i].pc);
      rdChk(4'h3, {3'b000, rows[i].sp});
      rdChk(4'h4, rows[i].top);
    end
    regWr(4'h1, 8'h12);
    regWr(4'h2, 8'h03);
    regWr(4'h0, 8'h57);
    chk(pc, 21'h031256);
    doOp(pcrs_pkg::OP_GOTO, 1'b0, 21'h054320);
    rdChk(4'h1, 8'h12);
    rdChk(4'h0, 8'h20);
    rdChk(4'h1, 8'h43);
    rdChk(4'h2, 8'h05);
    ctxNow <= 24'habcdef;
    doOp(pcrs_pkg::OP_CALL, 1'b1, 21'h000400);
    chk(ctxRestore, 24'habcdef);
    ctxNow <= 24'h111111;
    regWr(4'h4, 8'h40);
    regWr(4'h5, 8'h06);
    regWr(4'h6, 8'h00);
    doOp(pcrs_pkg::OP_RETURN, 1'b1, 21'h0);
    chk({restoreValid, ctxRestore}, {1'b1, 24'habcdef});
    chk(pc, 21'h000640);
    doOp(pcrs_pkg::OP_INTACK, 1'b0, 21'h000018);
    chk(ctxRestore, 24'h111111);
    doOp(pcrs_pkg::OP_RETURN_FROM_INTERRUPT, 1'b1, 21'h0);
    chk({restoreValid, ctxRestore, pc}, {1'b1, 24'h111111, 21'h000640});
    doOp(pcrs_pkg::OP_RETURN, 1'b0, 21'h0);
    chk({faultResetReq, pc}, {1'b0, 21'h0});
    rdChk(4'h3, 8'h40);
    regWr(4'h3, 8'h00);
    rdChk(4'h3, 8'h00);
    pushN(31);
    chk(faultResetReq, 1'b0);
    rdChk(4'h3, 8'h9f);
    regRd(4'h4, topSeen);
    pushN(1);
    rdChk(4'h3, 8'h9f);
    rdChk(4'h4, topSeen);
    regWr(4'h3, 8'h3f);
    rdChk(4'h3, 8'h1f);
    regWr(4'h3, 8'h00);
    doReset(1'b1, 1'b1);
    doOp(pcrs_pkg::OP_RETURN, 1'b0, 21'h0);
    chk(faultResetReq, 1'b1);
    doReset(1'b0, 1'b1);
    rdChk(4'h3, 8'h40);
    regWr(4'h3, 8'h00);
    pushN(30);
    chk(faultResetReq, 1'b0);
    doOp(pcrs_pkg::OP_CALL, 1'b0, 21'h000100);
    chk(faultResetReq, 1'b1);
    doReset(1'b0, 1'b1);
    rdChk(4'h3, 8'h80);
    finalReport();
  end
endmodule
